/* rtl/lhbe_pkg.sv */
// Constants, encodings and states of the LIN header and break engine.
// Assumes one 100 MHz clock; bit time is given in clock cycles by software.
package lhbe_pkg;

   // Clock
   localparam int          CLK_PERIOD_NS  = 10;

   // Mode encodings
   localparam logic [1:0]  LIN_FUNC_SEL   = 2'h1;
   localparam logic [1:0]  HDR_BREAK_ONLY = 2'h0;
   localparam logic [1:0]  HDR_BREAK_SYNC = 2'h1;
   localparam logic [1:0]  HDR_FULL       = 2'h2;

   // Byte framing
   localparam logic [7:0]  SYNC_BYTE      = 8'h55;
   localparam logic [7:0]  FRAME_LAST_BIT = 8'h09;
   localparam logic [3:0]  DATA_LAST_BIT  = 4'h7;

   // Break generation and detection
   localparam logic [3:0]  BREAK_BITS_RST = 4'hD;
   localparam logic [23:0] BRK_DET_BITS   = 24'h00000B;
   localparam logic [23:0] BRK_CNT_MAX    = 24'hFFFFFF;

   // Reset values
   localparam logic [15:0] BIT_CNT_RST    = 16'h0000;
   localparam logic [7:0]  BITS_LEFT_RST  = 8'h00;
   localparam logic [9:0]  SHIFT_RST      = 10'h3FF;
   localparam logic [2:0]  SIN_SYNC_RST   = 3'h7;

   typedef enum logic [2:0] {
      TX_IDLE  = 3'b000,
      TX_BREAK = 3'b001,
      TX_DELIM = 3'b010,
      TX_FRAME = 3'b011,
      TX_GAP   = 3'b100
   } lhbe_tx_state_e;

   typedef enum logic [1:0] {
      STG_NONE = 2'b00,
      STG_SYNC = 2'b01,
      STG_ID   = 2'b10
   } lhbe_stage_e;

   typedef enum logic [1:0] {
      RX_IDLE  = 2'b00,
      RX_START = 2'b01,
      RX_DATA  = 2'b10,
      RX_STOP  = 2'b11
   } lhbe_rx_state_e;

endpackage

/* rtl/lhbe_rx.sv */
// Byte receiver: start bit, eight data bits LSB first, one stop bit.
// Assumes rx_line is already synchronised and bit_clks is at least 2.
`timescale 1ns/1ns
module lhbe_rx
   import lhbe_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        srst,
   input  wire logic        enable,
   input  wire logic        rx_line,
   input  wire logic [15:0] bit_clks,
   output logic      [7:0]  rx_data,
   output logic             rx_valid
);

   lhbe_rx_state_e state_q;
   logic [15:0]    cnt_q;
   logic [3:0]     idx_q;
   logic [7:0]     shift_q;
   logic           line_prev_q;
   logic           at_mid;
   logic           at_end;

   assign at_mid = (cnt_q == (bit_clks >> 1));
   assign at_end = (cnt_q >= bit_clks - 16'h0001);

   // Own transmitted bytes come back here too, giving software its read-back
   always_ff @(posedge sys_clk) begin
      if (srst || !enable) begin
         state_q  <= RX_IDLE;
         cnt_q    <= BIT_CNT_RST;
         idx_q    <= 4'h0;
         shift_q  <= 8'h00;
         rx_data  <= 8'h00;
         rx_valid <= 1'b0;
         line_prev_q <= 1'b1;
      end else begin
         rx_valid <= 1'b0;
         line_prev_q <= rx_line;
         cnt_q    <= at_end ? BIT_CNT_RST : cnt_q + 16'h0001;
         unique case (state_q)
            RX_IDLE: begin
               cnt_q <= BIT_CNT_RST;
               // Falling edge only, so a long break is not read as many bytes
               if (!rx_line && line_prev_q) begin
                  state_q <= RX_START;
               end
            end
            RX_START: begin
               // Glitch shorter than half a bit is not a start
               if (at_mid && rx_line) begin
                  state_q <= RX_IDLE;
               end else if (at_end) begin
                  state_q <= RX_DATA;
                  idx_q   <= 4'h0;
               end
            end
            RX_DATA: begin
               if (at_mid) begin
                  shift_q <= {rx_line, shift_q[7:1]};
               end
               if (at_end) begin
                  idx_q <= idx_q + 4'h1;
                  if (idx_q == DATA_LAST_BIT) begin
                     state_q <= RX_STOP;
                  end
               end
            end
            RX_STOP: begin
               if (at_mid) begin
                  state_q  <= RX_IDLE;
                  rx_data  <= shift_q;
                  rx_valid <= rx_line;
               end
            end
         endcase
      end
   end

endmodule

/* rtl/lhbe_top.sv */
// LIN header and break engine of an asynchronous serial port.
// Assumes software drives the control ports and holds them stable per header.
// How it works
// - Port works as LIN only when function select equals 01.
// - Bytes are start 0, eight data bits LSB first, stop 1.
// - Header select 0 breaks, 1 adds sync, 2 adds identifier.
// - Full header sends break, sync, then the protected identifier field.
// - Parity enable makes hardware compute P0 and P1 from ID0-ID5.
// - Header request starts header; hardware clears it, then empty flag sets.
// - Bit error check flags input differing from output while transmitting.
// - Receiver captures own transmitted bytes for software read-back.
// - Break is break_length dominant bits, default 13, then delimiter.
// - Delimiter defaults to one bit and byte spacing to zero bits, adjustable by fields.
// - Break detect enable starts detector independent of the receiver.
// - Break flag sets when over 11 dominant bits end in recessive.
// - LIN interrupt enable raises interrupt on break detected flag.
// - Slave operation enters when slave enable is set in LIN mode.
// - Response bytes are sent from holding data, received from the bus.
`timescale 1ns/1ns
module lhbe_top
   import lhbe_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        srst,
   input  wire logic [1:0]  function_select,
   input  wire logic [15:0] baud_divider,
   input  wire logic [1:0]  header_select,
   input  wire logic [7:0]  protected_identifier,
   input  wire logic        identifier_parity_enable,
   input  wire logic        send_header_set,
   input  wire logic [3:0]  break_length,
   input  wire logic [1:0]  delimiter_length,
   input  wire logic [7:0]  transmit_gap_delay,
   input  wire logic        bit_error_enable,
   input  wire logic        bit_error_clear,
   input  wire logic        break_detect_enable,
   input  wire logic        break_flag_clear,
   input  wire logic        lin_interrupt_enable,
   input  wire logic        slave_enable,
   input  wire logic [7:0]  transmit_holding,
   input  wire logic        transmit_valid,
   output logic             transmit_ready,
   output logic [7:0]       receive_buffer,
   output logic             receive_available_flag,
   output logic             send_header_request,
   output logic             transmitter_empty_flag,
   output logic             break_detected_flag,
   output logic             bit_error_flag,
   output logic             lin_irq,
   output logic             slave_active,
   input  wire logic        serial_input_pin,
   output logic             serial_output_pin
);

   lhbe_tx_state_e tx_state_q;
   lhbe_stage_e    stage_q;
   logic [2:0]     sin_sync_q;
   logic           sin_q;
   logic           lin_mode;
   logic [15:0]    bit_cnt_q;
   logic           bit_end;
   logic           bit_late;
   logic [7:0]     bits_left_q;
   logic [9:0]     shift_q;
   logic [7:0]     pid_tx;
   logic           more_id;
   logic [7:0]     gap_left;
   logic [23:0]    low_cnt_q;
   logic [23:0]    brk_limit;
   logic           brk_set;
   logic           sin_prev_q;
   logic           err_set;

   assign lin_mode  = (function_select == LIN_FUNC_SEL);
   assign bit_end   = (bit_cnt_q >= baud_divider - 16'h0001);
   assign bit_late  = (bit_cnt_q == baud_divider - 16'h0002);
   assign more_id   = (stage_q == STG_SYNC) && (header_select == HDR_FULL);
   assign gap_left  = transmit_gap_delay - 8'h01;
   assign transmit_ready = lin_mode && (tx_state_q == TX_IDLE) && !send_header_request;

   // Hardware parity overrides the two top bits of the identifier
   assign pid_tx[5:0] = protected_identifier[5:0];
   assign pid_tx[6]   = identifier_parity_enable ?
                        (pid_tx[0] ^ pid_tx[1] ^ pid_tx[2] ^ pid_tx[4]) :
                        protected_identifier[6];
   assign pid_tx[7]   = identifier_parity_enable ?
                        ~(pid_tx[1] ^ pid_tx[3] ^ pid_tx[4] ^ pid_tx[5]) :
                        protected_identifier[7];

   // Pin synchroniser; a level counts once stages two and three agree
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         sin_sync_q <= SIN_SYNC_RST;
         sin_q      <= 1'b1;
      end else begin
         sin_sync_q <= {sin_sync_q[1:0], serial_input_pin};
         if (sin_sync_q[1] == sin_sync_q[2]) begin
            sin_q <= sin_sync_q[2];
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst || tx_state_q == TX_IDLE || bit_end) begin
         bit_cnt_q <= BIT_CNT_RST;
      end else begin
         bit_cnt_q <= bit_cnt_q + 16'h0001;
      end
   end

   // Software sets the request; a new set in the clearing cycle survives
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         send_header_request <= 1'b0;
      end else if (send_header_set) begin
         send_header_request <= 1'b1;
      end else if (stage_q != STG_NONE && tx_state_q == TX_IDLE) begin
         send_header_request <= 1'b0;
      end
   end

   // Transmit sequencer: break, delimiter, bytes, inter-byte gap
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         tx_state_q  <= TX_IDLE;
         stage_q     <= STG_NONE;
         bits_left_q <= BITS_LEFT_RST;
         shift_q     <= SHIFT_RST;
      end else begin
         unique case (tx_state_q)
            TX_IDLE: begin
               stage_q <= STG_NONE;
               shift_q <= SHIFT_RST;
               if (lin_mode && send_header_request && stage_q == STG_NONE) begin
                  tx_state_q  <= TX_BREAK;
                  stage_q     <= STG_SYNC;
                  bits_left_q <= {4'h0, break_length - 4'h1};
               end else if (transmit_ready && transmit_valid) begin
                  tx_state_q  <= TX_FRAME;
                  bits_left_q <= FRAME_LAST_BIT;
                  shift_q     <= {1'b1, transmit_holding, 1'b0};
               end
            end
            TX_BREAK: begin
               if (bit_end && bits_left_q == BITS_LEFT_RST) begin
                  tx_state_q  <= TX_DELIM;
                  bits_left_q <= {6'h00, delimiter_length};
               end else if (bit_end) begin
                  bits_left_q <= bits_left_q - 8'h01;
               end
            end
            TX_DELIM: begin
               if (bit_end && bits_left_q == BITS_LEFT_RST) begin
                  if (header_select == HDR_BREAK_ONLY) begin
                     tx_state_q <= TX_IDLE;
                  end else begin
                     tx_state_q  <= TX_FRAME;
                     bits_left_q <= FRAME_LAST_BIT;
                     shift_q     <= {1'b1, SYNC_BYTE, 1'b0};
                  end
               end else if (bit_end) begin
                  bits_left_q <= bits_left_q - 8'h01;
               end
            end
            TX_FRAME: begin
               if (bit_end && bits_left_q == BITS_LEFT_RST) begin
                  if (transmit_gap_delay != 8'h00) begin
                     tx_state_q  <= TX_GAP;
                     bits_left_q <= gap_left;
                  end else if (more_id) begin
                     stage_q     <= STG_ID;
                     bits_left_q <= FRAME_LAST_BIT;
                     shift_q     <= {1'b1, pid_tx, 1'b0};
                  end else begin
                     tx_state_q <= TX_IDLE;
                  end
               end else if (bit_end) begin
                  bits_left_q <= bits_left_q - 8'h01;
                  shift_q     <= {1'b1, shift_q[9:1]};
               end
            end
            TX_GAP: begin
               shift_q <= SHIFT_RST;
               if (bit_end && bits_left_q == BITS_LEFT_RST) begin
                  if (more_id) begin
                     tx_state_q  <= TX_FRAME;
                     stage_q     <= STG_ID;
                     bits_left_q <= FRAME_LAST_BIT;
                     shift_q     <= {1'b1, pid_tx, 1'b0};
                  end else begin
                     tx_state_q <= TX_IDLE;
                  end
               end else if (bit_end) begin
                  bits_left_q <= bits_left_q - 8'h01;
               end
            end
            default: begin
               tx_state_q <= TX_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         serial_output_pin <= 1'b1;
      end else if (tx_state_q == TX_BREAK) begin
         serial_output_pin <= 1'b0;
      end else if (tx_state_q == TX_FRAME) begin
         serial_output_pin <= shift_q[0];
      end else begin
         serial_output_pin <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         transmitter_empty_flag <= 1'b1;
      end else begin
         transmitter_empty_flag <= (tx_state_q == TX_IDLE) && !send_header_request;
      end
   end

   // Compare late in the bit: the echo lags about five cycles, so divider >= 7
   assign err_set = bit_error_enable && lin_mode && tx_state_q != TX_IDLE &&
                    bit_late && (sin_q != serial_output_pin);

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         bit_error_flag <= 1'b0;
      end else if (err_set) begin
         bit_error_flag <= 1'b1;
      end else if (bit_error_clear) begin
         bit_error_flag <= 1'b0;
      end
   end

   // Break detector works from the pin alone, not from the receiver
   assign brk_limit = 24'(baud_divider) * BRK_DET_BITS;
   assign brk_set   = break_detect_enable && lin_mode && sin_q && !sin_prev_q &&
                      (low_cnt_q > brk_limit);

   always_ff @(posedge sys_clk) begin
      if (srst || !break_detect_enable) begin
         low_cnt_q  <= 24'h000000;
         sin_prev_q <= 1'b1;
      end else begin
         sin_prev_q <= sin_q;
         if (sin_q) begin
            low_cnt_q <= 24'h000000;
         end else if (low_cnt_q != BRK_CNT_MAX) begin
            low_cnt_q <= low_cnt_q + 24'h000001;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         break_detected_flag <= 1'b0;
      end else if (brk_set) begin
         break_detected_flag <= 1'b1;
      end else if (break_flag_clear) begin
         break_detected_flag <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         lin_irq <= 1'b0;
      end else begin
         lin_irq <= (lin_interrupt_enable && break_detected_flag) ||
                    bit_error_flag;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         slave_active <= 1'b0;
      end else begin
         slave_active <= lin_mode && slave_enable;
      end
   end

   lhbe_rx u_rx (
      .sys_clk  (sys_clk),
      .srst     (srst),
      .enable   (lin_mode),
      .rx_line  (sin_q),
      .bit_clks (baud_divider),
      .rx_data  (receive_buffer),
      .rx_valid (receive_available_flag)
   );

   default clocking @(posedge sys_clk); endclocking
   default disable iff (srst);

   chk_idle_recessive: assert property (
      tx_state_q == TX_IDLE |=> serial_output_pin || tx_state_q != TX_IDLE)
      else $error("Output not recessive while idle");

   chk_break_low: assert property (
      tx_state_q == TX_BREAK |=> !serial_output_pin)
      else $error("Break bit not dominant");

   chk_request_start: assert property (
      tx_state_q == TX_IDLE && lin_mode && send_header_request && stage_q == STG_NONE
      |=> tx_state_q == TX_BREAK)
      else $error("Header request did not start a break");

   chk_sync_follows: assert property (
      tx_state_q == TX_DELIM && bit_end && bits_left_q == BITS_LEFT_RST &&
      header_select != HDR_BREAK_ONLY
      |=> tx_state_q == TX_FRAME && shift_q[8:1] == SYNC_BYTE)
      else $error("Sync byte not sent after delimiter");

   chk_id_load: assert property (
      stage_q == STG_ID && tx_state_q == TX_FRAME && bits_left_q == FRAME_LAST_BIT
      |-> shift_q[8:1] == pid_tx && !shift_q[0])
      else $error("Identifier frame not loaded");

   chk_break_flag: assert property (
      brk_set |=> break_detected_flag)
      else $error("Break flag missed");

   chk_break_irq: assert property (
      lin_interrupt_enable && break_detected_flag |=> lin_irq)
      else $error("Break interrupt missing");

   chk_bit_error: assert property (
      err_set |=> bit_error_flag ##1 lin_irq)
      else $error("Bit error not flagged");

   chk_empty_after: assert property (
      $fell(send_header_request) && !send_header_set |=> transmitter_empty_flag)
      else $error("Empty flag not set after header");

   chk_lin_gate: assert property (
      !lin_mode |-> !transmit_ready)
      else $error("Transmit accepted outside LIN mode");

endmodule

/* verif/lhbe_bus_node.sv */
// Another node on the single-wire bus: sends bytes, breaks and stuck-low glitches.
// Assumes a wired-AND bus with pull-up, so a released line reads recessive.
`timescale 1ns/1ns
module lhbe_bus_node
(
   input  wire logic [15:0] bit_clks,
   input  wire logic        sys_clk,
   output logic             node_line
);
   initial node_line = 1'b1;

   // Changes only at falling edges, away from the sampling edge
   task automatic drive(input logic lvl, input int cycles);
      node_line = lvl;
      repeat (cycles) @(negedge sys_clk);
   endtask

   task automatic send_byte(input logic [7:0] b);
      drive(1'b0, bit_clks);
      for (int i = 0; i < 8; i++) drive(b[i], bit_clks);
      drive(1'b1, bit_clks);
   endtask

   task automatic send_break(input int bits);
      drive(1'b0, bits * bit_clks);
      drive(1'b1, bit_clks);
   endtask
endmodule

/* verif/tb.sv */
// Self-checking bench for the LIN header and break engine with one bus partner.
// Assumes the serial input sees the wired-AND of our output and the partner.
`timescale 1ns/1ns
module tb;
   localparam int DIV = 8;
   logic        sys_clk = 1'b0, srst = 1'b1;
   logic [1:0]  function_select = 2'h0, header_select = 2'h0, delimiter_length = 2'h0;
   logic [7:0]  protected_identifier = 8'h00, transmit_gap_delay = 8'h00;
   logic [7:0]  transmit_holding = 8'h00, b;
   logic [3:0]  break_length = 4'hD;
   logic [15:0] baud_divider = 16'h0008;
   logic        identifier_parity_enable = 0, send_header_set = 0, bit_error_enable = 0;
   logic        bit_error_clear = 0, break_detect_enable = 0, break_flag_clear = 0;
   logic        lin_interrupt_enable = 0, slave_enable = 0, transmit_valid = 0;
   logic        transmit_ready, receive_available_flag, send_header_request;
   logic        transmitter_empty_flag, break_detected_flag, bit_error_flag, lin_irq;
   logic        slave_active, serial_output_pin, node_line;
   logic [7:0]  receive_buffer;
   wire         serial_input_pin = serial_output_pin & node_line;
   logic [7:0]  rxq[$];
   int          fails = 0, checked = 0, cycles = 0, n;

   lhbe_top lhbe_top_inst (.sys_clk, .srst, .function_select, .baud_divider,
      .header_select, .protected_identifier, .identifier_parity_enable, .send_header_set,
      .break_length, .delimiter_length, .transmit_gap_delay, .bit_error_enable,
      .bit_error_clear, .break_detect_enable, .break_flag_clear, .lin_interrupt_enable,
      .slave_enable, .transmit_holding, .transmit_valid, .transmit_ready, .receive_buffer,
      .receive_available_flag, .send_header_request, .transmitter_empty_flag,
      .break_detected_flag, .bit_error_flag, .lin_irq, .slave_active, .serial_input_pin,
      .serial_output_pin);
   lhbe_bus_node lhbe_bus_node_inst (.bit_clks(baud_divider), .sys_clk, .node_line);

   always #5 sys_clk = ~sys_clk;

   // Read-back capture; registered outputs are seen before the edge updates them
   always @(posedge sys_clk) begin
      cycles++;
      if (receive_available_flag === 1'b1) rxq.push_back(receive_buffer);
      if (cycles == 20000) begin
         fails++;
         conclude();
      end
   end

   task automatic conclude();
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic chk1(input string what, input logic e, input logic g);
      checked++;
      if (g !== e) begin
         fails++;
         $display("wrong value %s expected %b seen %b", what, e, g);
      end
   endtask

   task automatic chk8(input string what, input logic [7:0] e, input logic [7:0] g);
      checked++;
      if (g !== e) begin
         fails++;
         $display("wrong value %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic chkn(input string what, input int e, input int g);
      checked++;
      if (g != e) begin
         fails++;
         $display("wrong value %s expected %0d seen %0d", what, e, g);
      end
   endtask

   task automatic tick(input int k);
      repeat (k) @(negedge sys_clk);
   endtask

   // Length of the current run of one level on the output, in cycles
   task automatic run(input logic lvl, output int cnt);
      cnt = 0;
      while (serial_output_pin === lvl && cnt < 4000) begin
         cnt++;
         tick(1);
      end
   endtask

   // Entered on the first low sample of a start bit; samples at mid-bit
   task automatic rd_frame(output logic [7:0] v);
      tick(DIV / 2);
      chk1("start bit", 1'b0, serial_output_pin);
      for (int i = 0; i < 8; i++) begin
         tick(DIV);
         v[i] = serial_output_pin;
      end
      tick(DIV);
      chk1("stop bit", 1'b1, serial_output_pin);
   endtask

   task automatic hdr();
      send_header_set = 1'b1;
      tick(1);
      send_header_set = 1'b0;
   endtask

   task automatic wait_req();
      while (send_header_request !== 1'b0) tick(1);
   endtask

   task automatic send_byte(input logic [7:0] v);
      transmit_holding = v;
      transmit_valid = 1'b1;
      while (transmit_ready !== 1'b1) tick(1);
      tick(1);
      transmit_valid = 1'b0;
      tick(1);
   endtask

   function automatic logic [7:0] par(input logic [7:0] id);
      return {~(id[1] ^ id[3] ^ id[4] ^ id[5]), id[0] ^ id[1] ^ id[2] ^ id[4], id[5:0]};
   endfunction

   initial begin
      tick(10);
      srst = 1'b0;
      tick(1);
      chk1("idle output", 1'b1, serial_output_pin);
      chk1("empty after reset", 1'b1, transmitter_empty_flag);
      chk1("request after reset", 1'b0, send_header_request);
      function_select = 2'h1;
      bit_error_enable = 1'b1;
      break_detect_enable = 1'b1;
      header_select = 2'h2;
      protected_identifier = 8'hC5;
      identifier_parity_enable = 1'b1;
      transmit_gap_delay = 8'h02;
      tick(2);
      hdr();
      tick(1);
      chk1("request set", 1'b1, send_header_request);
      chk1("empty busy", 1'b0, transmitter_empty_flag);
      chk1("ready busy", 1'b0, transmit_ready);
      run(1'b1, n);
      run(1'b0, n);
      chkn("break", 13 * DIV, n);
      run(1'b1, n);
      chkn("delimiter", DIV, n);
      rd_frame(b);
      chk8("sync", 8'h55, b);
      run(1'b1, n);
      chkn("gap", DIV - DIV / 2 + 2 * DIV, n);
      rd_frame(b);
      chk8("identifier", par(8'hC5), b);
      wait_req();
      tick(1);
      chk1("empty done", 1'b1, transmitter_empty_flag);
      tick(30);
      chk8("echo sync", 8'h55, rxq.pop_front());
      chk8("echo id", par(8'hC5), rxq.pop_front());
      chk1("break seen", 1'b1, break_detected_flag);
      chk1("irq gated", 1'b0, lin_irq);
      break_flag_clear = 1'b1;
      tick(1);
      break_flag_clear = 1'b0;
      // Eleven dominant bits are one short of a detectable break
      header_select = 2'h1;
      break_length = 4'hB;
      delimiter_length = 2'h2;
      transmit_gap_delay = 8'h00;
      identifier_parity_enable = 1'b0;
      hdr();
      run(1'b1, n);
      run(1'b0, n);
      chkn("short break", 11 * DIV, n);
      run(1'b1, n);
      chkn("long delimiter", 3 * DIV, n);
      rd_frame(b);
      chk8("hw sync", 8'h55, b);
      wait_req();
      tick(30);
      chk1("short break ignored", 1'b0, break_detected_flag);
      fork
         send_byte(8'h9A);
         begin
            run(1'b1, n);
            rd_frame(b);
         end
      join
      chk8("sw id", 8'h9A, b);
      tick(30);
      chk8("echo sync2", 8'h55, rxq.pop_front());
      chk8("echo id2", 8'h9A, rxq.pop_front());
      header_select = 2'h0;
      break_length = 4'hD;
      delimiter_length = 2'h0;
      transmit_gap_delay = 8'h01;
      lin_interrupt_enable = 1'b1;
      hdr();
      run(1'b1, n);
      run(1'b0, n);
      chkn("break only", 13 * DIV, n);
      wait_req();
      tick(30);
      chk1("break flag", 1'b1, break_detected_flag);
      chk1("break irq", 1'b1, lin_irq);
      chk1("output idle after break", 1'b1, serial_output_pin);
      break_flag_clear = 1'b1;
      tick(1);
      break_flag_clear = 1'b0;
      tick(2);
      chk1("irq cleared", 1'b0, lin_irq);
      fork
         begin
            send_byte(8'h55);
            while (receive_available_flag !== 1'b1) tick(1);
            send_byte(8'h2F);
         end
         begin
            run(1'b1, n);
            rd_frame(b);
            chk8("sw sync", 8'h55, b);
            run(1'b1, n);
            // One idle cycle passes while the next byte is taken
            chkn("byte gap", DIV - DIV / 2 + DIV + 1, n);
            rd_frame(b);
            chk8("sw id2", 8'h2F, b);
         end
      join
      tick(30);
      chk1("no bit error", 1'b0, bit_error_flag);
      chk8("echo sw sync", 8'h55, rxq.pop_front());
      chk8("echo sw id", 8'h2F, rxq.pop_front());
      // Header request held while not in LIN mode
      function_select = 2'h0;
      slave_enable = 1'b1;
      hdr();
      n = 0;
      repeat (300) begin
         tick(1);
         if (serial_output_pin !== 1'b1) n++;
      end
      chkn("silent off LIN", 0, n);
      chk1("slave off", 1'b0, slave_active);
      function_select = 2'h1;
      run(1'b1, n);
      run(1'b0, n);
      chkn("late break", 13 * DIV, n);
      chk1("slave on", 1'b1, slave_active);
      wait_req();
      slave_enable = 1'b0;
      tick(30);
      break_flag_clear = 1'b1;
      tick(1);
      break_flag_clear = 1'b0;
      fork
         send_byte(8'hFF);
         begin
            tick(6 * DIV);
            lhbe_bus_node_inst.drive(1'b0, 2 * DIV);
            lhbe_bus_node_inst.drive(1'b1, 0);
         end
      join
      tick(20 * DIV);
      chk1("bit error", 1'b1, bit_error_flag);
      chk1("bit error irq", 1'b1, lin_irq);
      bit_error_clear = 1'b1;
      tick(1);
      bit_error_clear = 1'b0;
      tick(2);
      chk1("bit error cleared", 1'b0, bit_error_flag);
      rxq.delete();
      lhbe_bus_node_inst.send_byte(8'hA3);
      tick(DIV);
      chk8("from partner", 8'hA3, rxq.pop_front());
      lhbe_bus_node_inst.send_break(12);
      tick(DIV);
      chk1("partner break", 1'b1, break_detected_flag);
      chk1("partner break irq", 1'b1, lin_irq);
      tick(10);
      conclude();
   end
endmodule
